// *** hdl/ra0_pkg.sv ***
// Shared constants and types for the alarm 0 match and interrupt block
package ra0_pkg;

  localparam int RA0_DATA_W = 8;
  localparam int RA0_IDX_W = 3;
  localparam int RA0_NUM_FIELDS = 6;

  // Register indices on the register access port
  localparam logic [2:0] RA0_IDX_SECONDS = 3'h0;
  localparam logic [2:0] RA0_IDX_MINUTES = 3'h1;
  localparam logic [2:0] RA0_IDX_HOURS = 3'h2;
  localparam logic [2:0] RA0_IDX_DATE = 3'h3;
  localparam logic [2:0] RA0_IDX_MONTH = 3'h4;
  localparam logic [2:0] RA0_IDX_WEEKDAY = 3'h5;
  localparam logic [2:0] RA0_IDX_INT_CTRL = 3'h6;
  localparam logic [2:0] RA0_IDX_STATUS = 3'h7;

  // Field positions
  localparam int RA0_FIELD_EN_BIT = 7;
  localparam int RA0_IM_BIT = 7;
  localparam int RA0_ALARM0_ENABLE_BIT = 5;
  localparam int RA0_AL0_FLAG_BIT = 5;

  // Values after reset
  localparam logic [7:0] RA0_CMP_RESET = 8'h00;
  localparam logic [7:0] RA0_INT_RESET = 8'h00;
  localparam logic [7:0] RA0_RD_RESET = 8'h00;

  // Pulse width of the periodic interrupt
  localparam int RA0_CLK_MHZ = 100;
  localparam int RA0_PULSE_MS = 250;
  localparam int RA0_PULSE_CYCLES = RA0_PULSE_MS * RA0_CLK_MHZ * 1000;

  // Current calendar value from the timekeeping counters, BCD per field
  typedef struct packed {
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } ra0_time_s;

  // One access on the register port
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [2:0] idx;
    logic [7:0] wr_data;
  } ra0_reg_req_s;

endpackage

// *** hdl/ra0_field_cmp.sv ***
// One alarm field comparator: enable bit plus BCD value
`timescale 1ns/10ps
module ra0_field_cmp
  import ra0_pkg::*;
#(
  parameter int FIELD_W = 8
) (
  input wire logic [FIELD_W-1:0] compare,
  input wire logic [FIELD_W-1:0] current,
  output logic match
);

  assign match = !compare[FIELD_W-1] ||
    (compare[FIELD_W-2:0] == current[FIELD_W-2:0]);

endmodule

// *** hdl/ra0_pulse_gen.sv ***
// Fixed width pulse timer for the periodic interrupt
`timescale 1ns/10ps
module ra0_pulse_gen
  import ra0_pkg::*;
#(
  parameter int CYCLES = RA0_PULSE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start,
  output logic active
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (start) begin
      next_count = CNT_LOAD;
    end else if (count != '0) begin
      next_count = count - CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign active = (count != '0);

endmodule

// *** hdl/ra0_alarm.sv ***
// Alarm 0 compare, status flag and interrupt output of the clock/calendar
//
// Notes on behaviour
// - Compare register top bit enables the field, lower bits hold BCD target.
// - A compare register with enable clear never blocks a match.
// - Match is judged only when the clock steps to a new second.
// - A match sets alarm0_flag and drives irq_freq_out_n low.
// - Mode bit 0 gives one interrupt per match, a single event.
// - Mode bit 1 gives a pulse on the output at every match.
// - Seconds-only compare at 30 fires once each minute at second 30.
// - Pulsed mode sets the flag each time; no clear needed for more pulses.
// - Mode select is interrupt control bit 7, alarm enable bit 5.
`timescale 1ns/10ps
module ra0_alarm
  import ra0_pkg::*;
#(
  parameter int PULSE_CYCLES = RA0_PULSE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sec_tick,
  input wire ra0_time_s cur_time,
  input wire ra0_reg_req_s reg_req,
  output logic [7:0] reg_rd_data,
  output logic alarm0_flag,
  output logic irq_freq_out_n
);

  logic [7:0] cmp_reg [RA0_NUM_FIELDS];
  logic [7:0] next_cmp_reg [RA0_NUM_FIELDS];
  logic [7:0] int_ctrl;
  logic [7:0] next_int_ctrl;
  logic next_alarm0_flag;
  logic [7:0] next_reg_rd_data;
  logic next_irq_freq_out_n;
  logic [7:0] cur_field [RA0_NUM_FIELDS];
  logic [RA0_NUM_FIELDS-1:0] field_match;
  logic fire;
  logic pulse_active;
  logic interrupt_mode_select;
  logic alarm0_enable;
  logic flag_clear;

  assign cur_field[0] = cur_time.seconds;
  assign cur_field[1] = cur_time.minutes;
  assign cur_field[2] = cur_time.hours;
  assign cur_field[3] = cur_time.date;
  assign cur_field[4] = cur_time.month;
  assign cur_field[5] = cur_time.weekday;

  assign interrupt_mode_select = int_ctrl[RA0_IM_BIT];
  assign alarm0_enable = int_ctrl[RA0_ALARM0_ENABLE_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < RA0_NUM_FIELDS; gi++) begin : g_field
      ra0_field_cmp #(
        .FIELD_W(RA0_DATA_W)
      ) u_cmp (
        .compare(cmp_reg[gi]),
        .current(cur_field[gi]),
        .match(field_match[gi])
      );
    end
  endgenerate

  assign fire = sec_tick && alarm0_enable && (&field_match);

  // Register writes
  always_comb begin
    for (int i = 0; i < RA0_NUM_FIELDS; i++) begin
      next_cmp_reg[i] = cmp_reg[i];
    end
    next_int_ctrl = int_ctrl;
    if (reg_req.wr_en) begin
      if (reg_req.idx < RA0_IDX_INT_CTRL) begin
        next_cmp_reg[reg_req.idx] = reg_req.wr_data;
      end else if (reg_req.idx == RA0_IDX_INT_CTRL) begin
        next_int_ctrl = reg_req.wr_data;
      end
    end
  end

  // Status flag: write zero to clear, a match in the same cycle wins
  assign flag_clear = reg_req.wr_en && (reg_req.idx == RA0_IDX_STATUS) &&
    !reg_req.wr_data[RA0_AL0_FLAG_BIT];

  always_comb begin
    next_alarm0_flag = alarm0_flag;
    if (flag_clear) begin
      next_alarm0_flag = 1'b0;
    end
    if (fire) begin
      next_alarm0_flag = 1'b1;
    end
  end

  // Read data, registered one cycle after the request
  always_comb begin
    next_reg_rd_data = reg_rd_data;
    if (reg_req.rd_en) begin
      next_reg_rd_data = RA0_RD_RESET;
      if (reg_req.idx < RA0_IDX_INT_CTRL) begin
        next_reg_rd_data = cmp_reg[reg_req.idx];
      end else if (reg_req.idx == RA0_IDX_INT_CTRL) begin
        next_reg_rd_data = int_ctrl;
      end else begin
        next_reg_rd_data[RA0_AL0_FLAG_BIT] = alarm0_flag;
      end
    end
  end

  ra0_pulse_gen #(
    .CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(fire && interrupt_mode_select),
    .active(pulse_active)
  );

  always_comb begin
    if (interrupt_mode_select) begin
      next_irq_freq_out_n = !pulse_active;
    end else begin
      next_irq_freq_out_n = !next_alarm0_flag;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < RA0_NUM_FIELDS; i++) begin
        cmp_reg[i] <= RA0_CMP_RESET;
      end
      int_ctrl <= RA0_INT_RESET;
      alarm0_flag <= 1'b0;
      reg_rd_data <= RA0_RD_RESET;
      irq_freq_out_n <= 1'b1;
    end else begin
      for (int i = 0; i < RA0_NUM_FIELDS; i++) begin
        cmp_reg[i] <= next_cmp_reg[i];
      end
      int_ctrl <= next_int_ctrl;
      alarm0_flag <= next_alarm0_flag;
      reg_rd_data <= next_reg_rd_data;
      irq_freq_out_n <= next_irq_freq_out_n;
    end
  end

endmodule

// *** verification/ra0_host.sv ***
// Host side driver of the register port
`timescale 1ns/10ps
module ra0_host
  import ra0_pkg::*;
(
  input wire logic sys_clk,
  output ra0_reg_req_s reg_req
);
  initial reg_req = '0;
  task automatic acc(ra0_reg_req_s q);
    @(negedge sys_clk);
    reg_req = q;
    @(posedge sys_clk);
  endtask
endmodule

// *** verification/ra0_sva.sv ***
// Port assertions for the alarm block
`timescale 1ns/10ps
module ra0_sva
  import ra0_pkg::*;
#(parameter int PULSE_CYCLES = 8) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sec_tick,
  input wire ra0_time_s cur_time,
  input wire ra0_reg_req_s reg_req,
  input wire logic [7:0] reg_rd_data,
  input wire logic alarm0_flag,
  input wire logic irq_freq_out_n
);
  logic m, en;
  int lo;
  wire w7 = reg_req.wr_en && reg_req.idx == 3'h7;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {m, en} <= 2'h0;
      lo <= 0;
    end else begin
      if (reg_req.wr_en && reg_req.idx == 3'h6)
        {m, en} <= {reg_req.wr_data[7], reg_req.wr_data[5]};
      lo <= irq_freq_out_n ? 0 : lo + 1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_rd;
    reg_req.rd_en && reg_req.idx == 3'h7 |=>
      reg_rd_data == {2'h0, $past(alarm0_flag), 5'h00};
  endproperty
  property p_tk; $rose(alarm0_flag) |-> $past(sec_tick); endproperty
  property p_en; $rose(alarm0_flag) |-> $past(en); endproperty
  property p_clr; w7 && !reg_req.wr_data[5] && !sec_tick |=> !alarm0_flag;
  endproperty
  property p_hld; alarm0_flag && !w7 |=> alarm0_flag; endproperty
  property p_sgl; !m && $stable(m) |-> irq_freq_out_n == !alarm0_flag;
  endproperty
  property p_pst; m && $rose(alarm0_flag) |=> !irq_freq_out_n; endproperty
  property p_pw; m && $rose(irq_freq_out_n) |->
    lo >= PULSE_CYCLES - 1 && lo <= PULSE_CYCLES; endproperty
  a_rd: assert property (p_rd) else $error("status read");
  a_tk: assert property (p_tk) else $error("set off tick");
  a_en: assert property (p_en) else $error("set disabled");
  a_clr: assert property (p_clr) else $error("no clear");
  a_hld: assert property (p_hld) else $error("flag lost");
  a_sgl: assert property (p_sgl) else $error("single irq");
  a_pst: assert property (p_pst) else $error("pulse start");
  a_pw: assert property (p_pw) else $error("pulse width");
  c_sgl: cover property (!m && $rose(alarm0_flag));
  c_pls: cover property (m && $fell(irq_freq_out_n));
  c_clr: cover property ($fell(alarm0_flag));
endmodule
bind ra0_alarm ra0_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (.sys_clk,
  .rstn, .sec_tick, .cur_time, .reg_req, .reg_rd_data, .alarm0_flag,
  .irq_freq_out_n);

// *** verification/tb_top.sv ***
// Self-checking bench for the alarm block
`timescale 1ns/10ps
module tb_top
  import ra0_pkg::*;
;
  logic sys_clk = 1'b0, rstn = 1'b0, sec_tick = 1'b0, flg = 1'b0, f;
  logic alarm0_flag, irq_freq_out_n;
  logic [7:0] reg_rd_data, ctl = 8'h00;
  logic [7:0] cmp [6] = '{default: 8'h00};
  logic [7:0] ex [6] = '{8'h00, 8'hB0, 8'h91, 8'h81, 8'h81, 8'h00};
  ra0_time_s cur_time = '0;
  ra0_reg_req_s reg_req;
  int mismatches = 0, checks_done = 0, cyc = 0, n;
  int unsigned s = 21;
  ra0_alarm #(.PULSE_CYCLES(8)) DUT (.sys_clk, .rstn, .sec_tick,
    .cur_time, .reg_req, .reg_rd_data, .alarm0_flag, .irq_freq_out_n);
  ra0_host u_host (.sys_clk, .reg_req);
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 3000) begin
    mismatches++;
    test_done();
  end
  function automatic logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task automatic test_done();
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s %h %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [2:0] i, logic [7:0] d);
    u_host.acc({1'b1, 1'b0, i, d});
    if (i < 6) cmp[i] = d;
    else if (i == 6) ctl = d;
    else if (!d[5]) flg = 1'b0;
  endtask
  task automatic rd(logic [2:0] i);
    u_host.acc({1'b0, 1'b1, i, 8'h00});
    u_host.acc('0);
    chk("reg", i < 6 ? cmp[i] : i > 6 ? {2'h0, flg, 5'h00} : ctl,
      reg_rd_data);
  endtask
  task automatic tick(logic [7:0] sc, mn);
    u_host.acc('0);
    @(negedge sys_clk);
    cur_time = {rnd(), 24'h010111, mn, sc};
    sec_tick = 1'b1;
    f = ctl[5];
    for (int i = 0; i < 6; i++)
      if (cmp[i][7] && cmp[i][6:0] != cur_time[8*i+:7]) f = 1'b0;
    flg |= f;
    @(negedge sys_clk);
    sec_tick = 1'b0;
    chk("flag", 8'(flg), 8'(alarm0_flag));
    if (!ctl[7]) chk("irq", 8'(!flg), 8'(irq_freq_out_n));
    n = 0;
    repeat (14) @(negedge sys_clk) n += int'(irq_freq_out_n !== 1'b1);
    if (ctl[7]) chk("pulse", 8'h01, 8'(f ? n == 7 || n == 8 : n == 0));
    if (!ctl[7]) chk("hold", 8'(flg ? 14 : 0), 8'(n));
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) rd(3'(i));
    for (int i = 0; i < 7; i++) begin
      wr(3'(i), rnd());
      rd(3'(i));
    end
    for (int i = 0; i < 6; i++) wr(3'(i), ex[i]);
    wr(3'h6, 8'h00);
    tick(8'h00, 8'h30);
    wr(3'h6, 8'h20);
    tick(8'h59, 8'h29);
    tick(8'h00, 8'h30);
    tick(8'h01, 8'h30);
    rd(3'h7);
    wr(3'h7, 8'h00);
    tick(8'h00, 8'h31);
    for (int i = 0; i < 6; i++) wr(3'(i), i ? 8'h00 : 8'hB0);
    wr(3'h6, 8'hA0);
    for (int k = 0; k < 6; k++)
      tick(k % 3 == 0 ? 8'h29 : k % 3 == 1 ? 8'h30 : 8'h31, rnd());
    rd(3'h7);
    test_done();
  end
endmodule
